// file: hw/clpwm_cfg_reg.sv
// one 32-bit read/write configuration register with reset value
// assumes same-clock write strobe from the decoder
`timescale 1ns/1ps
`default_nettype none
module clpwm_cfg_reg #(
	parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic we_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] q_o
);
	logic [31:0] next_q;
	always_comb begin
		next_q = we_i ? wdata_i : q_o;
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_o <= RESET_VAL;
		end else begin
			q_o <= next_q;
		end
	end
endmodule
`default_nettype wire

// file: hw/clpwm_pkg.sv
// constants for the closed-loop drive configuration registers
// assumes a plain register port with one-cycle read latency
// Behaviour
// - frequency codes 0h..Fh select 5 to 20 kHz in 1 kHz steps
// - modulation field: 0 high side, 1 low side, 2 mixed, 3 reserved
// - drive bit: 0 single-ended, 1 complementary switching
// - advance sign bit: 0 negative lead, 1 positive lead
// - advance angle field times 0.12 gives lead angle in degrees
// - second register sits at offset 88h and resets to zero
// - bit 31 of each register is a read/write parity bit, reset zero
`default_nettype none
package clpwm_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CFG_A_OFFSET = 8'h84;
	localparam logic [7:0] CFG_B_OFFSET = 8'h88;
	localparam logic [31:0] CFG_A_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_B_RESET = 32'h0000_0000;
	localparam int PARITY_BIT = 31;
	localparam int FREQ_HI = 17;
	localparam int FREQ_LO = 13;
	localparam int MOD_HI = 12;
	localparam int MOD_LO = 11;
	localparam int DRIVE_BIT = 10;
	localparam int SIGN_BIT = 9;
	localparam int ANGLE_HI = 8;
	localparam int ANGLE_LO = 1;
	localparam logic [4:0] FREQ_STEP_LIMIT = 5'h0F;
	localparam logic [6:0] FREQ_BASE_KHZ = 7'h05;
	localparam logic [6:0] FREQ_UPPER_BASE_KHZ = 7'h19;
	localparam logic [6:0] FREQ_UPPER_STEP_KHZ = 7'h05;
	// lead angle in milli-degrees per code step (0.12 deg)
	localparam logic [7:0] ANGLE_MDEG_PER_LSB = 8'h78;
	typedef enum logic [2:0] {
		CLPWM_MOD_HIGH = 3'h1,
		CLPWM_MOD_LOW = 3'h2,
		CLPWM_MOD_MIXED = 3'h4
	} clpwm_mod_t;
endpackage
`default_nettype wire

// file: hw/clpwm_regs.sv
// closed-loop drive configuration registers and field decode
// assumes a single 10 MHz clock and a same-clock register master
`timescale 1ns/1ps
`default_nettype none
module clpwm_regs (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic [31:0] cfg_a_o,
	output logic [31:0] cfg_b_o,
	output logic [6:0] switch_freq_khz_o,
	output logic freq_code_reserved_o,
	output logic mod_high_side_o,
	output logic mod_low_side_o,
	output logic mod_mixed_o,
	output logic mod_reserved_o,
	output logic complementary_o,
	output logic advance_positive_o,
	output logic [15:0] advance_mdeg_o
);
	logic [31:0] cfg_a;
	logic [31:0] cfg_b;
	logic we_a;
	logic we_b;
	logic [31:0] next_rdata;
	logic [4:0] fcode;
	logic [1:0] mcode;
	logic [7:0] acode;
	logic [6:0] next_khz;
	logic next_frsv;
	logic [2:0] next_mod;
	logic next_mrsv;
	logic next_comp;
	logic next_pos;
	logic [15:0] next_mdeg;
	logic [2:0] mod_q;

	assign we_a = wr_i && (addr_i == clpwm_pkg::CFG_A_OFFSET);
	assign we_b = wr_i && (addr_i == clpwm_pkg::CFG_B_OFFSET);

	// all 32 bits stored, parity and reserved included
	clpwm_cfg_reg #(
		.RESET_VAL(clpwm_pkg::CFG_A_RESET)
	) u_cfg_a (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.we_i(we_a),
		.wdata_i(wdata_i),
		.q_o(cfg_a)
	);
	clpwm_cfg_reg #(
		.RESET_VAL(clpwm_pkg::CFG_B_RESET)
	) u_cfg_b (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.we_i(we_b),
		.wdata_i(wdata_i),
		.q_o(cfg_b)
	);

	assign fcode = cfg_a[clpwm_pkg::FREQ_HI:clpwm_pkg::FREQ_LO];
	assign mcode = cfg_a[clpwm_pkg::MOD_HI:clpwm_pkg::MOD_LO];
	assign acode = cfg_a[clpwm_pkg::ANGLE_HI:clpwm_pkg::ANGLE_LO];

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				clpwm_pkg::CFG_A_OFFSET: next_rdata = cfg_a;
				clpwm_pkg::CFG_B_OFFSET: next_rdata = cfg_b;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		// every five-bit code maps to a frequency, so the flag stays low
		next_frsv = 1'b0;
		if (fcode <= clpwm_pkg::FREQ_STEP_LIMIT) begin
			next_khz = clpwm_pkg::FREQ_BASE_KHZ + {3'h0, fcode[3:0]};
		end else begin
			// 5 kHz steps from 25 kHz; 15h lands on 50 kHz
			next_khz = 7'(clpwm_pkg::FREQ_UPPER_BASE_KHZ
				+ 7'(clpwm_pkg::FREQ_UPPER_STEP_KHZ * {3'h0, fcode[3:0]}));
		end
		next_mrsv = 1'b0;
		case (mcode)
			2'h0: next_mod = clpwm_pkg::CLPWM_MOD_HIGH;
			2'h1: next_mod = clpwm_pkg::CLPWM_MOD_LOW;
			2'h2: next_mod = clpwm_pkg::CLPWM_MOD_MIXED;
			default: begin
				next_mod = 3'h0;
				next_mrsv = 1'b1;
			end
		endcase
		next_comp = cfg_a[clpwm_pkg::DRIVE_BIT];
		next_pos = cfg_a[clpwm_pkg::SIGN_BIT];
		next_mdeg = 16'({8'h00, acode} * {8'h00, clpwm_pkg::ANGLE_MDEG_PER_LSB});
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0000_0000;
			switch_freq_khz_o <= 7'h00;
			freq_code_reserved_o <= 1'b0;
			mod_q <= 3'h0;
			mod_reserved_o <= 1'b0;
			complementary_o <= 1'b0;
			advance_positive_o <= 1'b0;
			advance_mdeg_o <= 16'h0000;
		end else begin
			rdata_o <= next_rdata;
			switch_freq_khz_o <= next_khz;
			freq_code_reserved_o <= next_frsv;
			mod_q <= next_mod;
			mod_reserved_o <= next_mrsv;
			complementary_o <= next_comp;
			advance_positive_o <= next_pos;
			advance_mdeg_o <= next_mdeg;
		end
	end

	assign mod_high_side_o = mod_q[0];
	assign mod_low_side_o = mod_q[1];
	assign mod_mixed_o = mod_q[2];
	assign cfg_a_o = cfg_a;
	assign cfg_b_o = cfg_b;

	freq_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(fcode) == 5'h03) |-> (switch_freq_khz_o == 7'h08))
		else $error("code 3h must give 8 kHz");
	freq_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(fcode) == 5'h15) |-> (switch_freq_khz_o == 7'h32))
		else $error("code 15h must give 50 kHz");
	mod_mixed_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(mcode) == 2'h2) |-> (mod_mixed_o && !mod_high_side_o))
		else $error("mixed modulation not selected");
	drive_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		we_a |=> ##1 (complementary_o == $past(wdata_i[10], 2)))
		else $error("drive mode not following write");
	sign_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		we_a |=> ##1 (advance_positive_o == $past(wdata_i[9], 2)))
		else $error("advance sign not following write");
	angle_scale_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(acode) == 8'h0A) |-> (advance_mdeg_o == 16'h04B0))
		else $error("lead angle scale wrong");
	sequence wr_b_s;
		we_b ##1 (rd_i && addr_i == clpwm_pkg::CFG_B_OFFSET && !wr_i);
	endsequence
	readback_b_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_b_s |=> (rdata_o == $past(wdata_i, 2)))
		else $error("second register readback wrong");
	parity_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		we_a |=> (cfg_a[31] == $past(wdata_i[31])))
		else $error("parity bit not stored");
	unmapped_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_i && addr_i != clpwm_pkg::CFG_A_OFFSET
		&& addr_i != clpwm_pkg::CFG_B_OFFSET) |=> (rdata_o == 32'h0))
		else $error("unmapped read not zero");

	// code-0 decode checks skip the first edge after reset, outputs still clear
	freq_base_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(rst_n_i) && $past(fcode) == 5'h00)
		|-> (switch_freq_khz_o == 7'h05))
		else $error("code 0h must give 5 kHz");
	freq_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(rst_n_i) && !$past(fcode[4])) |-> (switch_freq_khz_o
		== clpwm_pkg::FREQ_BASE_KHZ + {3'h0, $past(fcode[3:0])}))
		else $error("low codes not in 1 kHz steps");
	freq_twenty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(fcode) == 5'h0F) |-> (switch_freq_khz_o == 7'h14))
		else $error("code Fh must give 20 kHz");
	freq_upper_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(fcode) == 5'h10) |-> (switch_freq_khz_o == 7'h19))
		else $error("code 10h must give 25 kHz");
	freq_thirty_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(fcode) == 5'h11) |-> (switch_freq_khz_o == 7'h1E))
		else $error("code 11h must give 30 kHz");
	freq_max_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(fcode) == 5'h1F) |-> (switch_freq_khz_o == 7'h64))
		else $error("code 1Fh must give 100 kHz");
	mod_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(rst_n_i) && $past(mcode) == 2'h0)
		|-> (mod_high_side_o && !mod_low_side_o
		&& !mod_mixed_o && !mod_reserved_o))
		else $error("high-side modulation not selected");
	mod_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(mcode) == 2'h1) |-> (mod_low_side_o && !mod_high_side_o
		&& !mod_mixed_o && !mod_reserved_o))
		else $error("low-side modulation not selected");
	mod_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(mcode) == 2'h3) |-> (mod_reserved_o && !mod_high_side_o
		&& !mod_low_side_o && !mod_mixed_o))
		else $error("reserved modulation code not flagged");
	drive_track_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		complementary_o == $past(cfg_a[clpwm_pkg::DRIVE_BIT]))
		else $error("drive mode does not track register");
	sign_track_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		advance_positive_o == $past(cfg_a[clpwm_pkg::SIGN_BIT]))
		else $error("advance sign does not track register");
	angle_track_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		advance_mdeg_o == 16'({8'h00, $past(acode)}
		* {8'h00, clpwm_pkg::ANGLE_MDEG_PER_LSB}))
		else $error("lead angle does not track register");
	angle_max_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($past(acode) == 8'hFF) |-> (advance_mdeg_o == 16'h7788))
		else $error("full lead angle code scaled wrong");
	cfg_a_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		we_a |=> (cfg_a == $past(wdata_i)))
		else $error("first register write lost");
	cfg_a_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!we_a |=> (cfg_a == $past(cfg_a)))
		else $error("first register changed without write");
	cfg_b_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		we_b |=> (cfg_b == $past(wdata_i)))
		else $error("second register write lost");
	cfg_b_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!we_b |=> (cfg_b == $past(cfg_b)))
		else $error("second register changed without write");
	parity_b_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		we_b |=> (cfg_b[clpwm_pkg::PARITY_BIT]
		== $past(wdata_i[clpwm_pkg::PARITY_BIT])))
		else $error("second parity bit not stored");
	read_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_i && addr_i == clpwm_pkg::CFG_A_OFFSET)
		|=> (rdata_o == $past(cfg_a)))
		else $error("first register readback wrong");
	idle_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!rd_i |=> (rdata_o == 32'h0000_0000))
		else $error("read data not cleared without read");
	reset_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> (cfg_a == clpwm_pkg::CFG_A_RESET
		&& cfg_b == clpwm_pkg::CFG_B_RESET))
		else $error("registers not clear after reset");
endmodule
`default_nettype wire

// file: tb/clpwm_regs_tb.sv
// self-checking bench for the closed-loop drive configuration registers
// assumes clpwm_regs and clpwm_pkg compiled first; 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module closed_loop_pwm_config_regs_tb_top;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o, cfg_a_o, cfg_b_o;
	logic [6:0] switch_freq_khz_o;
	logic freq_code_reserved_o, mod_high_side_o, mod_low_side_o;
	logic mod_mixed_o, mod_reserved_o, complementary_o, advance_positive_o;
	logic [15:0] advance_mdeg_o;
	int fails = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h0000_0025;
	logic [31:0] d, b;
	logic [7:0] a;

	clpwm_regs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.cfg_a_o(cfg_a_o), .cfg_b_o(cfg_b_o),
		.switch_freq_khz_o(switch_freq_khz_o),
		.freq_code_reserved_o(freq_code_reserved_o),
		.mod_high_side_o(mod_high_side_o), .mod_low_side_o(mod_low_side_o),
		.mod_mixed_o(mod_mixed_o), .mod_reserved_o(mod_reserved_o),
		.complementary_o(complementary_o),
		.advance_positive_o(advance_positive_o),
		.advance_mdeg_o(advance_mdeg_o));

	always #50 clk_i = ~clk_i;

	function automatic logic [31:0] rand_word();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] exp_khz(input logic [4:0] c);
		return (c <= 5'h0F) ? 32'h5 + c : 32'h19 + 32'h5 * (c - 5'h10);
	endfunction

	task automatic wrap_up();
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] wa, input logic [31:0] wd);
		@(posedge clk_i);
		addr_i <= wa;
		wdata_i <= wd;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] ra, input logic [31:0] exp);
		@(posedge clk_i);
		addr_i <= ra;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
		@(posedge clk_i);
		#1 chk(rdata_o, 32'h0);
	endtask

	// write then read back on the very next cycle, no idle edge between
	task automatic wr_rd(input logic [7:0] wa, input logic [31:0] wd);
		@(posedge clk_i);
		addr_i <= wa;
		wdata_i <= wd;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, wd);
		@(posedge clk_i);
		#1 chk(rdata_o, 32'h0);
	endtask

	// decoded outputs settle one cycle after the raw register
	task automatic chk_decode(input logic [31:0] v);
		@(posedge clk_i);
		#1 chk({25'h0, switch_freq_khz_o}, exp_khz(v[17:13]));
		chk({31'h0, freq_code_reserved_o}, 32'h0);
		chk({28'h0, mod_reserved_o, mod_mixed_o, mod_low_side_o,
			mod_high_side_o}, 32'h1 << v[12:11]);
		chk({31'h0, complementary_o}, {31'h0, v[10]});
		chk({31'h0, advance_positive_o}, {31'h0, v[9]});
		chk({16'h0, advance_mdeg_o}, v[8:1] * 32'h78);
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		chk_decode(32'h0);
		rd(8'h84, 32'h0);
		rd(8'h88, 32'h0);
		for (int i = 0; i < 64; i++) begin
			d = (i == 63) ? 32'hFFFF_FFFF : rand_word();
			d[17:13] = i[4:0];
			d[12:11] = i[5:4];
			if (i == 10)
				d[8:1] = 8'h0A;
			wr(8'h84, d);
			chk(cfg_a_o, d);
			chk_decode(d);
			rd(8'h84, d);
			b = rand_word();
			wr_rd(8'h88, b);
			chk(cfg_b_o, b);
			a = 8'(rand_word());
			if (a == 8'h84 || a == 8'h88)
				a = 8'h8C;
			wr(a, rand_word());
			chk(cfg_a_o, d);
			chk(cfg_b_o, b);
			rd(a, 32'h0);
		end
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		#1 chk(cfg_a_o | cfg_b_o, 32'h0);
		chk({25'h0, switch_freq_khz_o}, 32'h0);
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		chk_decode(32'h0);
		rd(8'h88, 32'h0);
		wrap_up();
	end

	// about 1000 cycles expected; cut off well beyond
	initial begin
		#500000;
		fails++;
		wrap_up();
	end
endmodule
`default_nettype wire
